//--- sra_ramp_ctrl.sv
`timescale 1ns/1ps
module sra_ramp_ctrl
   import sra_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   // Parameter writes
   input  wire logic [13:0] param_wdata_in,
   input  wire logic        wr_mode_in,
   input  wire logic        wr_dir_in,
   input  wire logic        wr_ref_in,
   input  wire logic        wr_acc_ratio_in,
   input  wire logic        wr_dec_ratio_in,
   // Settings held elsewhere
   input  wire logic [15:0] accel_time_setting_in,
   input  wire logic [15:0] decel_time_setting_in,
   input  wire logic [13:0] constant_speed_stall_level_in,
   input  wire logic [13:0] rated_current_in,
   // Drive status
   input  wire logic        running_in,
   input  wire logic        accel_in,
   input  wire logic        decel_in,
   input  wire logic [15:0] load_current_in,
   // External pins
   input  wire logic        jog_in,
   input  wire logic        second_function_select_in,
   // Settings readback
   output logic      [7:0]  auto_ramp_mode_select_out,
   output logic      [1:0]  ramp_direction_select_out,
   output logic      [13:0] stall_reference_current_out,
   output logic      [13:0] accel_limit_ratio_out,
   output logic      [13:0] decel_limit_ratio_out,
   // Ramp control
   output logic      [15:0] ramp_time_out,
   output logic             shortest_ramp_out,
   output logic             ramp_hold_out,
   output logic      [15:0] stall_level_out,
   output logic      [1:0]  brake_sequence_out,
   output logic             jog_grant_out,
   output logic             second_function_grant_out
);

   // ==========================================================
   // Pin synchronisers
   logic [1:0] pin_raw;
   wire  [1:0] pin_sync;

   assign pin_raw = {second_function_select_in, jog_in};

   // One flop pair per pin, each pair owning its own registers
   genvar gi;
   generate
      for (gi = 0; gi < $bits(pin_raw); gi++) begin : g_sync
         logic sync1_q;
         logic sync2_q;
         always_ff @(posedge mclk_in) begin
            if (sys_rst_in) begin
               sync1_q <= 1'b0;
               sync2_q <= 1'b0;
            end else begin
               sync1_q <= pin_raw[gi];
               sync2_q <= sync1_q;
            end
         end
         assign pin_sync[gi] = sync2_q;
      end
   endgenerate

   wire jog_s = pin_sync[0];
   wire sfs_s = pin_sync[1];

   // ==========================================================
   // Parameter store
   logic [7:0]  mode_q;
   logic [1:0]  dir_q;
   logic [13:0] ref_q;
   logic [13:0] acc_ratio_q;
   logic [13:0] dec_ratio_q;
   logic [7:0]  mode_d;
   logic [1:0]  dir_d;
   logic [13:0] ref_d;
   logic [13:0] acc_ratio_d;
   logic [13:0] dec_ratio_d;

   wire [7:0] wmode = param_wdata_in[7:0];
   wire mode_ok = (param_wdata_in[13:8] == 6'h00) &&
                  ((wmode == SRA_MODE_NORMAL) || sra_is_shortest(wmode) ||
                   (wmode == SRA_MODE_BRSEQ1) || (wmode == SRA_MODE_BRSEQ2));
   wire mode_change = wr_mode_in && mode_ok && (wmode != mode_q);
   wire dir_ok = (param_wdata_in <= 14'(SRA_DIR_DEC));
   wire ref_ok = sra_in_range(param_wdata_in, SRA_REF_MAX);
   wire ratio_ok = sra_in_range(param_wdata_in, SRA_RATIO_MAX);

   // A mode change beats a same-cycle write to the dependent settings
   assign mode_d      = mode_change ? wmode : mode_q;
   assign dir_d       = (wr_dir_in && dir_ok) ? param_wdata_in[1:0] : dir_q;
   assign ref_d       = mode_change ? SRA_UNSET :
                        (wr_ref_in && ref_ok) ? param_wdata_in : ref_q;
   assign acc_ratio_d = mode_change ? SRA_UNSET :
                        (wr_acc_ratio_in && ratio_ok) ? param_wdata_in : acc_ratio_q;
   assign dec_ratio_d = mode_change ? SRA_UNSET :
                        (wr_dec_ratio_in && ratio_ok) ? param_wdata_in : dec_ratio_q;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         mode_q      <= SRA_MODE_RST;
         dir_q       <= SRA_DIR_RST;
         ref_q       <= SRA_PARAM_RST;
         acc_ratio_q <= SRA_PARAM_RST;
         dec_ratio_q <= SRA_PARAM_RST;
      end else begin
         mode_q      <= mode_d;
         dir_q       <= dir_d;
         ref_q       <= ref_d;
         acc_ratio_q <= acc_ratio_d;
         dec_ratio_q <= dec_ratio_d;
      end
   end

   // ==========================================================
   // Stall levels
   wire [13:0] ref_eff = sra_pick(ref_q, rated_current_in);
   logic [15:0] acc_level;
   logic [15:0] dec_level;
   logic [15:0] const_level;

   sra_stall_level u_acc_level (
      .mclk_in     (mclk_in),
      .sys_rst_in  (sys_rst_in),
      .ref_amps_in (ref_eff),
      .ratio_in    (acc_ratio_q),
      .level_out   (acc_level)
   );

   sra_stall_level u_dec_level (
      .mclk_in     (mclk_in),
      .sys_rst_in  (sys_rst_in),
      .ref_amps_in (ref_eff),
      .ratio_in    (dec_ratio_q),
      .level_out   (dec_level)
   );

   sra_stall_level u_const_level (
      .mclk_in     (mclk_in),
      .sys_rst_in  (sys_rst_in),
      .ref_amps_in (rated_current_in),
      .ratio_in    (constant_speed_stall_level_in),
      .level_out   (const_level)
   );

   // ==========================================================
   // Jog and second function arbitration
   logic override_q;
   logic override_d;
   logic jog_grant_q;
   logic sfs_grant_q;

   wire auto_sel     = sra_is_shortest(mode_q);
   wire stopped      = !running_in;
   wire any_req      = jog_s || sfs_s;
   wire eff_shortest = auto_sel && !override_q;
   // A request seen while stopped latches normal mode until the drive stops with both released
   assign override_d = (stopped && auto_sel && any_req) ? 1'b1 :
                       (stopped && !any_req) ? 1'b0 : override_q;
   wire block_req    = running_in && eff_shortest;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         override_q  <= 1'b0;
         jog_grant_q <= 1'b0;
         sfs_grant_q <= 1'b0;
      end else begin
         override_q  <= override_d;
         jog_grant_q <= jog_s && !block_req;
         sfs_grant_q <= sfs_s && !block_req;
      end
   end

   // ==========================================================
   // Ramp tracking
   sra_ramp_type state_q;
   sra_ramp_type state_d;

   always_comb begin
      case (state_q)
         RAMP_IDLE,
         RAMP_CONST,
         RAMP_ACC,
         RAMP_DEC: begin
            if (!running_in) begin
               state_d = RAMP_IDLE;
            end else if (accel_in) begin
               state_d = RAMP_ACC;
            end else if (decel_in) begin
               state_d = RAMP_DEC;
            end else begin
               state_d = RAMP_CONST;
            end
         end
         default: begin
            state_d = RAMP_IDLE;
         end
      endcase
   end

   wire acc_start = (state_d == RAMP_ACC) && (state_q != RAMP_ACC);
   wire dec_start = (state_d == RAMP_DEC) && (state_q != RAMP_DEC);
   wire acc_allow = (dir_q == SRA_DIR_BOTH) || (dir_q == SRA_DIR_ACC);
   wire dec_allow = (dir_q == SRA_DIR_BOTH) || (dir_q == SRA_DIR_DEC);
   wire short_acc = eff_shortest && acc_allow;
   wire short_dec = eff_shortest && dec_allow;
   wire [15:0] short_dec_time = (mode_q == SRA_MODE_SHORT_BR) ? SRA_SHORT_DEC_BR
                                                             : SRA_SHORT_DEC_TIME;

   // Settings are only read here; the chosen time is latched per ramp
   wire [15:0] acc_time = short_acc ? SRA_SHORT_ACC_TIME : accel_time_setting_in;
   wire [15:0] dec_time = short_dec ? short_dec_time : decel_time_setting_in;

   logic [15:0] ramp_time_q;
   logic        shortest_q;
   logic        hold_q;
   logic [15:0] level_q;
   logic [1:0]  brake_q;

   wire in_ramp = (state_q == RAMP_ACC) || (state_q == RAMP_DEC);
   wire [15:0] level_sel = (shortest_q && (state_q == RAMP_ACC)) ? acc_level :
                           (shortest_q && (state_q == RAMP_DEC)) ? dec_level : const_level;
   // A shortest ramp pauses while current is at the limit, so real ramp time tracks load
   wire hold_d = in_ramp && shortest_q && (load_current_in >= level_sel);

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_q     <= RAMP_IDLE;
         ramp_time_q <= 16'h0000;
         shortest_q  <= 1'b0;
         hold_q      <= 1'b0;
         level_q     <= 16'h0000;
         brake_q     <= 2'h0;
      end else begin
         state_q <= state_d;
         if (acc_start) begin
            ramp_time_q <= acc_time;
            shortest_q  <= short_acc;
         end else if (dec_start) begin
            ramp_time_q <= dec_time;
            shortest_q  <= short_dec;
         end
         hold_q  <= hold_d;
         level_q <= level_sel;
         brake_q <= {mode_q == SRA_MODE_BRSEQ2, mode_q == SRA_MODE_BRSEQ1};
      end
   end

   // ==========================================================
   // Outputs
   assign auto_ramp_mode_select_out   = mode_q;
   assign ramp_direction_select_out   = dir_q;
   assign stall_reference_current_out = ref_q;
   assign accel_limit_ratio_out       = acc_ratio_q;
   assign decel_limit_ratio_out       = dec_ratio_q;
   assign ramp_time_out               = ramp_time_q;
   assign shortest_ramp_out           = shortest_q;
   assign ramp_hold_out               = hold_q;
   assign stall_level_out             = level_q;
   assign brake_sequence_out          = brake_q;
   assign jog_grant_out               = jog_grant_q;
   assign second_function_grant_out   = sfs_grant_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_stopped_jog;
      stopped && auto_sel && !override_q && jog_s;
   endsequence

   sequence s_forced_normal;
      override_q && jog_grant_q;
   endsequence

   chk_mode_clears_params: assert property (mode_change |=>
      (ref_q == SRA_UNSET) && (acc_ratio_q == SRA_UNSET) && (dec_ratio_q == SRA_UNSET))
      else $error("settings not reset after mode change");

   chk_ref_range_kept: assert property (
      (wr_ref_in && !ref_ok && !mode_change) |=> $stable(ref_q))
      else $error("out of range reference accepted");

   chk_short_acc_time: assert property ((acc_start && short_acc) |=>
      (ramp_time_q == SRA_SHORT_ACC_TIME) && shortest_q)
      else $error("shortest acceleration time not applied");

   chk_brake_decel_time: assert property (
      (dec_start && short_dec && (mode_q == SRA_MODE_SHORT_BR)) |=> (ramp_time_q == SRA_SHORT_DEC_BR))
      else $error("braked deceleration time not applied");

   chk_normal_ramp_time: assert property ((acc_start && !short_acc) |=>
      (ramp_time_q == $past(accel_time_setting_in)) && !shortest_q)
      else $error("stored acceleration time not used");

   chk_dir_accel_only: assert property (
      (dec_start && (dir_q == SRA_DIR_ACC)) |=> !shortest_q)
      else $error("deceleration shortened in accel only mode");

   chk_jog_priority: assert property (s_stopped_jog |=> s_forced_normal)
      else $error("jog not given priority while stopped");

   chk_jog_ignored: assert property ((running_in && eff_shortest && jog_s) |=> !jog_grant_q)
      else $error("jog honoured while running in automatic mode");

   chk_hold_on_load: assert property (
      (in_ramp && shortest_q && (load_current_in >= level_sel)) |=> (hold_q && (level_q == $past(level_sel))))
      else $error("ramp not held at stall level");

   chk_const_level: assert property ((state_q == RAMP_CONST) |=> (level_q == $past(const_level)))
      else $error("constant speed level not used");

   chk_brake_decode: assert property ((mode_q == SRA_MODE_BRSEQ1) |=> (brake_q == 2'h1))
      else $error("brake sequence mode 1 not decoded");

endmodule

//--- sra_pkg.sv
package sra_pkg;

   // ==========================================================
   // Parameter encodings and limits
   localparam logic [13:0] SRA_UNSET         = 14'h270f;
   localparam logic [13:0] SRA_REF_MAX       = 14'h01f4;
   localparam logic [13:0] SRA_RATIO_MAX     = 14'h00c8;
   localparam logic [13:0] SRA_DEF_RATIO     = 14'h0096;
   localparam logic [27:0] SRA_PCT_DIV       = 28'h0000064;

   localparam logic [7:0]  SRA_MODE_NORMAL   = 8'h00;
   localparam logic [7:0]  SRA_MODE_SHORT    = 8'h01;
   localparam logic [7:0]  SRA_MODE_SHORT_BR = 8'h0b;
   localparam logic [7:0]  SRA_MODE_BRSEQ1   = 8'h07;
   localparam logic [7:0]  SRA_MODE_BRSEQ2   = 8'h08;

   localparam logic [1:0]  SRA_DIR_BOTH      = 2'h0;
   localparam logic [1:0]  SRA_DIR_ACC       = 2'h1;
   localparam logic [1:0]  SRA_DIR_DEC       = 2'h2;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  SRA_MODE_RST      = SRA_MODE_NORMAL;
   localparam logic [1:0]  SRA_DIR_RST       = SRA_DIR_BOTH;
   localparam logic [13:0] SRA_PARAM_RST     = SRA_UNSET;

   // ==========================================================
   // Shortest ramp base times, in 0.01 s units
   localparam logic [15:0] SRA_SHORT_ACC_TIME = 16'h0032;
   localparam logic [15:0] SRA_SHORT_DEC_TIME = 16'h0064;
   localparam logic [15:0] SRA_SHORT_DEC_BR   = 16'h0032;

   localparam int          SRA_SYNC_STAGES   = 2;

   typedef enum logic [1:0] {
      RAMP_IDLE,
      RAMP_CONST,
      RAMP_ACC,
      RAMP_DEC
   } sra_ramp_type;

   // ==========================================================
   // Shared decoders
   function automatic logic [13:0] sra_pick(input logic [13:0] value, input logic [13:0] fallback);
      return (value == SRA_UNSET) ? fallback : value;
   endfunction

   function automatic logic sra_in_range(input logic [13:0] value, input logic [13:0] limit);
      return (value <= limit) || (value == SRA_UNSET);
   endfunction

   function automatic logic sra_is_shortest(input logic [7:0] mode);
      return (mode == SRA_MODE_SHORT) || (mode == SRA_MODE_SHORT_BR);
   endfunction

endpackage

//--- sra_stall_level.sv
`timescale 1ns/1ps
module sra_stall_level
   import sra_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   // Reference and ratio
   input  wire logic [13:0] ref_amps_in,
   input  wire logic [13:0] ratio_in,
   // Level in amps
   output logic      [15:0] level_out
);

   // ==========================================================
   // Level = reference * ratio / 100
   logic [15:0] level_q;
   wire  [13:0] ratio_eff;
   wire  [27:0] product;
   wire  [27:0] scaled;

   assign ratio_eff = sra_pick(ratio_in, SRA_DEF_RATIO);
   assign product   = 28'(ref_amps_in) * 28'(ratio_eff);
   // Constant divider; one cycle of latency keeps it off the compare path
   assign scaled    = product / SRA_PCT_DIV;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         level_q <= 16'h0000;
      end else begin
         level_q <= scaled[15:0];
      end
   end

   assign level_out = level_q;

endmodule

//--- sra_motor_model.sv
`timescale 1ns/1ps
module sra_motor_model (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   // Commanded motion: 0 stop, 1 constant, 2 accelerate, 3 decelerate
   input  wire logic [1:0]  cmd_in,
   input  wire logic [15:0] load_amps_in,
   // Drive status seen by the block
   output logic             running_out,
   output logic             accel_out,
   output logic             decel_out,
   output logic      [15:0] load_current_out
);
   // ==========================================================
   // Motion state, one cycle behind the command like a real drive
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         running_out      <= 1'b0;
         accel_out        <= 1'b0;
         decel_out        <= 1'b0;
         load_current_out <= 16'h0000;
      end else begin
         running_out      <= (cmd_in != 2'h0);
         accel_out        <= (cmd_in == 2'h2);
         decel_out        <= (cmd_in == 2'h3);
         // A stopped motor draws no current whatever the load
         load_current_out <= (cmd_in == 2'h0) ? 16'h0000 : load_amps_in;
      end
   end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CMP(got, exp, what) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value at %0t ns: output %0d got %h expected %h", $time, what, got, exp); end end
module testbench
   import sra_pkg::*;
;
   typedef struct {int sel; logic [15:0] val;} sra_note_type;
   // ==========================================================
   // Stimulus and observed signals
   logic        mclk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [13:0] wdata = 14'h0000;
   logic [4:0]  wr = 5'h00;
   logic [15:0] acc_t = 16'h0123, dec_t = 16'h0234, load = 16'h0000;
   logic [1:0]  cmd = 2'h0;
   logic        jog = 1'b0, sfs = 1'b0;
   logic        run_w, acc_w, dec_w;
   logic [15:0] cur_w, rtime_o, lvl_o;
   logic [7:0]  mode_o;
   logic [1:0]  dir_o, brk_o;
   logic [13:0] ref_o, accr_o, decr_o;
   logic        short_o, hold_o, jg_o, sg_o;
   logic [31:0] seed = 32'hf7c2317b;
   int          err_total = 0, n_checks = 0;
   sra_note_type notes[$];
   event        look;

   always #10 mclk_in = ~mclk_in;

   sra_motor_model u_sra_motor_model (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
      .load_amps_in(load), .running_out(run_w), .accel_out(acc_w), .decel_out(dec_w),
      .load_current_out(cur_w));

   sra_ramp_ctrl u_sra_ramp_ctrl (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .param_wdata_in(wdata),
      .wr_mode_in(wr[0]), .wr_dir_in(wr[1]), .wr_ref_in(wr[2]), .wr_acc_ratio_in(wr[3]),
      .wr_dec_ratio_in(wr[4]), .accel_time_setting_in(acc_t), .decel_time_setting_in(dec_t),
      .constant_speed_stall_level_in(14'h0050), .rated_current_in(14'h0064), .running_in(run_w),
      .accel_in(acc_w), .decel_in(dec_w), .load_current_in(cur_w), .jog_in(jog),
      .second_function_select_in(sfs), .auto_ramp_mode_select_out(mode_o),
      .ramp_direction_select_out(dir_o), .stall_reference_current_out(ref_o),
      .accel_limit_ratio_out(accr_o), .decel_limit_ratio_out(decr_o), .ramp_time_out(rtime_o),
      .shortest_ramp_out(short_o), .ramp_hold_out(hold_o), .stall_level_out(lvl_o),
      .brake_sequence_out(brk_o), .jog_grant_out(jg_o), .second_function_grant_out(sg_o));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [15:0] grab(input int s);
      case (s)
         0:       return {8'h00, mode_o};
         1:       return {14'h0000, dir_o};
         2:       return {2'h0, ref_o};
         3:       return {2'h0, accr_o};
         4:       return {2'h0, decr_o};
         5:       return rtime_o;
         6:       return {15'h0000, short_o};
         7:       return {15'h0000, hold_o};
         8:       return lvl_o;
         9:       return {14'h0000, brk_o};
         10:      return {15'h0000, jg_o};
         default: return {15'h0000, sg_o};
      endcase
   endfunction

   task automatic note(input int s, input logic [15:0] v);
      notes.push_back(sra_note_type'{s, v});
   endtask

   // Outputs are looked at mid-cycle, two edges after the stimulus; ending on a
   // rising edge lets the monitor drain before anything moves or the run ends
   task automatic sample();
      @(posedge mclk_in);
      @(negedge mclk_in);
      -> look;
      @(posedge mclk_in);
   endtask

   task automatic wr_p(input int k, input logic [13:0] d);
      @(posedge mclk_in);
      wr    <= 5'h01 << k;
      wdata <= d;
      @(posedge mclk_in);
      wr    <= 5'h00;
   endtask

   task automatic go(input logic [1:0] c, input int n);
      @(posedge mclk_in);
      cmd <= c;
      repeat (n) @(posedge mclk_in);
   endtask

   task automatic close_out();
      // A note never paired with an output is a miss too
      if (notes.size() != 0) begin
         err_total++;
      end
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Monitor: pairs every pending note with the output it names
   always begin
      @(look);
      while (notes.size() > 0) begin
         automatic sra_note_type n = notes.pop_front();
         `CMP(grab(n.sel), n.val, n.sel)
      end
   end

   initial begin
      #(20000 * 20);
      err_total++;
      close_out();
   end

   // ==========================================================
   // Ramp table: mode, direction, command, expected time (0 = stored, else shortest)
   int          t_mode[8] = '{1, 1, 11, 11, 11, 1, 1, 0};
   int          t_dir[8]  = '{0, 0, 0, 1, 1, 2, 2, 0};
   logic [1:0]  t_cmd[8]  = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2};
   logic [15:0] t_exp[8]  = '{16'h0032, 16'h0064, 16'h0032, 16'h0000, 16'h0032, 16'h0000, 16'h0064, 16'h0000};

   initial begin
      repeat (12) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      note(0, 16'h0000);
      note(1, 16'h0000);
      note(2, 16'h270f);
      note(3, 16'h270f);
      note(4, 16'h270f);
      note(9, 16'h0000);
      sample();
      $display("test reset done");
      // Settings: range checks, mode change side effect, brake modes
      wr_p(0, 14'h0001);
      wr_p(2, 14'h00c8);
      wr_p(3, 14'h0064);
      wr_p(4, 14'h01f4);
      wr_p(4, 14'h0032);
      wr_p(2, 14'h01f5);
      wr_p(3, 14'h00c9);
      note(2, 16'h00c8);
      note(3, 16'h0064);
      note(4, 16'h0032);
      sample();
      wr_p(0, 14'h0001);
      note(2, 16'h00c8);
      sample();
      wr_p(0, 14'h000b);
      note(0, 16'h000b);
      note(2, 16'h270f);
      note(3, 16'h270f);
      note(4, 16'h270f);
      sample();
      wr_p(0, 14'h0007);
      note(9, 16'h0001);
      sample();
      wr_p(0, 14'h0008);
      note(9, 16'h0002);
      sample();
      wr_p(0, 14'h0003);
      note(0, 16'h0008);
      sample();
      $display("test settings done");
      // Ramp start decisions with random stored times
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         acc_t <= seed[15:0];
         dec_t <= seed[31:16];
         wr_p(0, 14'(t_mode[i]));
         wr_p(1, 14'(t_dir[i]));
         go(2'h1, 3);
         go(t_cmd[i], 5);
         note(1, 16'(t_dir[i]));
         note(5, (t_exp[i] != 16'h0000) ? t_exp[i] : ((t_cmd[i] == 2'h2) ? acc_t : dec_t));
         note(6, {15'h0000, t_exp[i] != 16'h0000});
         sample();
         go(2'h0, 3);
      end
      $display("test ramps done");
      // Stall levels: rated 100 A, constant level 80 percent
      wr_p(0, 14'h0001);
      wr_p(1, 14'h0000);
      go(2'h1, 5);
      note(8, 16'h0050);
      sample();
      go(2'h2, 5);
      note(8, 16'h0096);
      sample();
      load <= 16'h00a0;
      repeat (4) @(posedge mclk_in);
      note(7, 16'h0001);
      sample();
      load <= 16'h000a;
      repeat (4) @(posedge mclk_in);
      note(7, 16'h0000);
      sample();
      go(2'h1, 3);
      wr_p(2, 14'h00c8);
      wr_p(3, 14'h0032);
      go(2'h2, 5);
      note(8, 16'h0064);
      sample();
      go(2'h1, 3);
      go(2'h3, 5);
      note(8, 16'h012c);
      sample();
      go(2'h0, 5);
      $display("test levels done");
      // Jog and second function against automatic mode
      jog <= 1'b1;
      repeat (5) @(posedge mclk_in);
      note(10, 16'h0001);
      go(2'h2, 5);
      note(6, 16'h0000);
      sample();
      jog <= 1'b0;
      go(2'h0, 6);
      go(2'h2, 5);
      note(6, 16'h0001);
      jog <= 1'b1;
      sfs <= 1'b1;
      repeat (5) @(posedge mclk_in);
      note(10, 16'h0000);
      note(11, 16'h0000);
      sample();
      jog <= 1'b0;
      go(2'h0, 6);
      note(11, 16'h0001);
      sample();
      $display("test requests done");
      close_out();
   end
endmodule
